// [pkg/sbs_pkg.sv]
/*
  Shared constants and types for the clocked two-way bus select block.
  Assumes one 50 MHz clock and an active-low asynchronous reset.
*/
package sbs_pkg;

  // Width of the switched data path
  localparam int unsigned DATA_W = 16;

  // Number of alternate ports behind the common port
  localparam int unsigned ALT_N = 2;

  // Reset release synchroniser depth
  localparam int unsigned RST_SYNC_N = 2;

  // Index of each alternate port in the per-port vectors
  localparam int unsigned ALT_FIRST_IDX  = 0;
  localparam int unsigned ALT_SECOND_IDX = 1;

  // Connection function, coded as {sel_high_bit, sel_low_bit}
  typedef enum logic [1:0] {
    SBS_FN_OPEN   = 2'h0,
    SBS_FN_BOTH   = 2'h1,
    SBS_FN_FIRST  = 2'h2,
    SBS_FN_SECOND = 2'h3
  } sbs_func_t;

  // Function held after reset
  localparam sbs_func_t FUNC_RESET = SBS_FN_OPEN;

  // Output values held after reset
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic              OE_RESET   = 1'h0;

  // True when the function closes the switch towards alternate port idx
  function automatic logic sbs_links_alt(input sbs_func_t fn, input int unsigned idx);
    logic hit;
    hit = 1'b0;
    unique case (fn)
      SBS_FN_OPEN:   hit = 1'b0;
      SBS_FN_BOTH:   hit = 1'b1;
      SBS_FN_FIRST:  hit = (idx == ALT_FIRST_IDX);
      SBS_FN_SECOND: hit = (idx == ALT_SECOND_IDX);
    endcase
    return hit;
  endfunction

endpackage

// [pkg/sbs_sel_if.sv]
/*
  Carrier between the function register and the data path.
  Assumes both ends sit on the same clock.
*/
interface sbs_sel_if;

  sbs_pkg::sbs_func_t func;     // Registered connection function

  // Function register end
  modport ctl (
    output func
  );

  // Data path end
  modport use_side (
    input func
  );

endinterface

// [rtl/sbs_func_reg.sv]
/*
  Holds the connection function of the bus select.
  Assumes select and gate inputs are synchronous to sys_clk and a
  reset already released in step with the clock.
*/
module sbs_func_reg (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_int_n,
  // Control inputs
  input  wire logic sel_low_bit,
  input  wire logic sel_high_bit,
  input  wire logic update_gate_n,
  // Function out
  sbs_sel_if.ctl    sel
);

  sbs_pkg::sbs_func_t func_q;

  // Load only on an enabled edge; otherwise the last function stays
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      func_q <= sbs_pkg::FUNC_RESET;
    end else if (!update_gate_n) begin
      unique case ({sel_high_bit, sel_low_bit})
        2'h0: func_q <= sbs_pkg::SBS_FN_OPEN;
        2'h1: func_q <= sbs_pkg::SBS_FN_BOTH;
        2'h2: func_q <= sbs_pkg::SBS_FN_FIRST;
        2'h3: func_q <= sbs_pkg::SBS_FN_SECOND;
      endcase
    end  // Gate high: hold
  end

  assign sel.func = func_q;

endmodule  // sbs_func_reg

// [rtl/sbs_bus_select.sv]
/*
  Clocked 16-bit one-of-two bus select: a common port switched to the
  first, the second, both or neither alternate port.
  Assumes all inputs synchronous to sys_clk (50 MHz); the pads outside
  resolve each two-way port from its output enable. Direction of flow
  comes from the controller on flow_to_alt, since a digital core cannot
  sense which side drives.
*/
// Notes on behaviour
// - 16-bit path, common to either alternate port
// - Function reloads only on gated rising edge
// - Gate high keeps last function
// - Selects 00: common port isolated
// - Selects 01: common drives both; only first drives common
// - Selects 10: common joined to first only
// - Selects 11: common joined to second only
module sbs_bus_select #(
  parameter int unsigned DATA_W = sbs_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Control from the bus controller
  input  wire logic              sel_low_bit,
  input  wire logic              sel_high_bit,
  input  wire logic              update_gate_n,
  input  wire logic              flow_to_alt,
  // Common port
  input  wire logic [DATA_W-1:0] common_in,
  output logic      [DATA_W-1:0] common_out,
  output logic                   common_oe,
  // First alternate port
  input  wire logic [DATA_W-1:0] alt_port_first_in,
  output logic      [DATA_W-1:0] alt_port_first_out,
  output logic                   alt_port_first_oe,
  // Second alternate port
  input  wire logic [DATA_W-1:0] alt_port_second_in,
  output logic      [DATA_W-1:0] alt_port_second_out,
  output logic                   alt_port_second_oe,
  // Status
  output logic      [1:0]        func_state
);

  logic [sbs_pkg::RST_SYNC_N-1:0] rst_sync_q;
  logic                           rst_int_n;
  logic [DATA_W-1:0]              common_out_q;
  logic                           common_oe_q;
  logic [DATA_W-1:0]              alt_out_q [sbs_pkg::ALT_N];
  logic                           alt_oe_q  [sbs_pkg::ALT_N];
  logic [1:0]                     func_state_q;
  logic [DATA_W-1:0]              alt_in    [sbs_pkg::ALT_N];

  sbs_sel_if sel ();

  // Reset asserts at once but releases two clean edges later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[sbs_pkg::RST_SYNC_N-2:0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync_q[sbs_pkg::RST_SYNC_N-1];

  // Connection function register
  sbs_func_reg u_func (
    .sys_clk       (sys_clk),
    .rst_int_n     (rst_int_n),
    .sel_low_bit   (sel_low_bit),
    .sel_high_bit  (sel_high_bit),
    .update_gate_n (update_gate_n),
    .sel           (sel)
  );

  // Alternate inputs gathered so the common-port mux can index them
  assign alt_in[sbs_pkg::ALT_FIRST_IDX]  = alt_port_first_in;
  assign alt_in[sbs_pkg::ALT_SECOND_IDX] = alt_port_second_in;

  // Towards the alternate ports: each closed switch repeats the common
  // port; flow goes only one way so the pads never fight
  for (genvar g = 0; g < sbs_pkg::ALT_N; g++) begin : g_alt
    always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
        alt_oe_q[g]  <= sbs_pkg::OE_RESET;
        alt_out_q[g] <= sbs_pkg::DATA_RESET;
      end else begin
        alt_oe_q[g]  <= flow_to_alt && sbs_pkg::sbs_links_alt(sel.func, g);
        alt_out_q[g] <= common_in;
      end
    end
  end

  // Towards the common port: the first port wins when both are closed,
  // a limitation of modelling two joined buses with single drivers
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      common_oe_q  <= sbs_pkg::OE_RESET;
      common_out_q <= sbs_pkg::DATA_RESET;
    end else begin
      common_oe_q <= !flow_to_alt && (sel.func != sbs_pkg::SBS_FN_OPEN);
      if (sbs_pkg::sbs_links_alt(sel.func, sbs_pkg::ALT_FIRST_IDX)) begin
        common_out_q <= alt_in[sbs_pkg::ALT_FIRST_IDX];
      end else begin
        common_out_q <= alt_in[sbs_pkg::ALT_SECOND_IDX];
      end
    end
  end

  // Function code visible to the controller, aligned with the enables
  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      func_state_q <= sbs_pkg::FUNC_RESET;
    end else begin
      func_state_q <= sel.func;
    end
  end

  // Outputs straight from flops
  assign common_out          = common_out_q;
  assign common_oe           = common_oe_q;
  assign alt_port_first_out  = alt_out_q[sbs_pkg::ALT_FIRST_IDX];
  assign alt_port_first_oe   = alt_oe_q[sbs_pkg::ALT_FIRST_IDX];
  assign alt_port_second_out = alt_out_q[sbs_pkg::ALT_SECOND_IDX];
  assign alt_port_second_oe  = alt_oe_q[sbs_pkg::ALT_SECOND_IDX];
  assign func_state          = func_state_q;

endmodule  // sbs_bus_select

// [dv/sbs_bus_select_assertions.sv]
/* Port checker for the bus select.
   Assumes the bind below and a two-edge lag of the internal reset. */
module sbs_bus_select_assertions #(parameter int unsigned DATA_W = 16) (
  input wire logic              sys_clk, rst_n, sel_low_bit, sel_high_bit,
  input wire logic              update_gate_n, flow_to_alt, common_oe,
  input wire logic              alt_port_first_oe, alt_port_second_oe,
  input wire logic [DATA_W-1:0] common_in, common_out, alt_port_first_in,
  input wire logic [DATA_W-1:0] alt_port_first_out, alt_port_second_in, alt_port_second_out,
  input wire logic [1:0]        func_state
);
  logic [1:0] up_q;
  logic       rst_seen_q;
  logic [2:0] oe;
  assign oe = {common_oe, alt_port_first_oe, alt_port_second_oe};
  // Edges since release; gated samples count from the third
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  // Reset seen at an edge once; power-up contents are not judged before that
  always_ff @(posedge sys_clk)
    if (!rst_n) rst_seen_q <= 1'b1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_func_load: assert property (up_q[1] && !update_gate_n
    |-> ##2 func_state == $past({sel_high_bit, sel_low_bit}, 2)) else $error("load");
  a_func_hold: assert property (up_q[1] && update_gate_n
    |-> ##2 $stable(func_state)) else $error("hold");
  a_open_iso: assert property (func_state == 2'h0 |-> oe == 3'h0) else $error("open");
  a_both_link: assert property (func_state == 2'h1 && $stable(flow_to_alt)
    |-> oe == (flow_to_alt ? 3'h3 : 3'h4)) else $error("both");
  a_first_link: assert property (func_state == 2'h2 && $stable(flow_to_alt)
    |-> oe == (flow_to_alt ? 3'h2 : 3'h4)) else $error("first");
  a_second_link: assert property (func_state == 2'h3 && $stable(flow_to_alt)
    |-> oe == (flow_to_alt ? 3'h1 : 3'h4)) else $error("second");
  a_demux_data: assert property (oe[1:0] != 2'h0 |->
    (!alt_port_first_oe || alt_port_first_out == $past(common_in)) &&
    (!alt_port_second_oe || alt_port_second_out == $past(common_in))) else $error("demux");
  a_mux_data: assert property (common_oe |-> common_out ==
    (func_state == 2'h3 ? $past(alt_port_second_in) : $past(alt_port_first_in)))
    else $error("mux");
  a_reset_open: assert property (disable iff (1'b0) !rst_n && rst_seen_q
    |-> func_state == 2'h0 && oe == 3'h0) else $error("reset");
endmodule // sbs_bus_select_assertions

bind sbs_bus_select sbs_bus_select_assertions #(.DATA_W(DATA_W)) u_chk (.*);

// [dv/sbs_ctl_model.sv]
/* Bus controller model: selects, update gate and flow direction.
   Assumes run and phase change only while it idles. */
module sbs_ctl_model (
  input wire logic sys_clk, run, phase,
  output logic     sel_low_bit, sel_high_bit, update_gate_n, flow_to_alt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] n_q = 3'h0;
  initial {sel_high_bit, sel_low_bit, update_gate_n, flow_to_alt} = 4'h3;
  // Walk all four codes first, then random gating; selects move even when gated off
  always @(negedge sys_clk) begin
    flow_to_alt <= phase;
    update_gate_n <= !run || (n_q[2] && 1'($urandom));
    {sel_high_bit, sel_low_bit} <= n_q[2] ? 2'($urandom) : n_q[1:0];
    n_q <= !run ? 3'h0 : (n_q[2] ? n_q : n_q + 3'h1);
  end
endmodule // sbs_ctl_model

// [dv/sbs_bus_select_tb.sv]
/* Bench for the bus select: model drives control, bench drives data pads.
   Assumes the checker is bound in from its own file. */
module sbs_bus_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_n = 1'b0, run = 1'b0, phase = 1'b1;
  logic sel_low_bit, sel_high_bit, update_gate_n, flow_to_alt, c_oe, f_oe, s_oe;
  logic [15:0] c_in = 16'h0, f_in = 16'h0, s_in = 16'h0, c_out, f_out, s_out;
  logic [1:0] func_state, pend_q = 2'h0, up_q = 2'h0;
  logic [4:0] q[$];
  int error_cnt = 0, check_count = 0;
  initial forever #10 sys_clk = ~sys_clk;
  sbs_ctl_model ctl (.sys_clk(sys_clk), .run(run), .phase(phase), .sel_low_bit(sel_low_bit),
    .sel_high_bit(sel_high_bit), .update_gate_n(update_gate_n), .flow_to_alt(flow_to_alt));
  sbs_bus_select dut (.sys_clk(sys_clk), .rst_n(rst_n), .sel_low_bit(sel_low_bit),
    .sel_high_bit(sel_high_bit), .update_gate_n(update_gate_n), .flow_to_alt(flow_to_alt),
    .common_in(c_in), .common_out(c_out), .common_oe(c_oe), .alt_port_first_in(f_in),
    .alt_port_first_out(f_out), .alt_port_first_oe(f_oe), .alt_port_second_in(s_in),
    .alt_port_second_out(s_out), .alt_port_second_oe(s_oe), .func_state(func_state));
  task automatic check(string what, logic [4:0] exp, logic [4:0] seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Enables per code and flow, worked out apart from the design
  function automatic logic [2:0] exp_oe(logic [1:0] f, logic fl);
    if (f == 2'h0) return 3'h0;
    if (!fl) return 3'h4;
    return (f == 2'h1) ? 3'h3 : ((f == 2'h2) ? 3'h2 : 3'h1);
  endfunction
  // Fresh data on every pad each cycle
  always @(negedge sys_clk) begin
    c_in <= 16'($urandom);
    f_in <= 16'($urandom);
    s_in <= 16'($urandom);
  end
  // Note each counted gated edge; the answer lands two edges on
  always @(posedge sys_clk) begin
    up_q <= !rst_n ? 2'h0 : ((up_q == 2'h3) ? up_q : up_q + 2'h1);
    pend_q <= {pend_q[0], up_q[1] && !update_gate_n};
    if (up_q[1] && !update_gate_n)
      q.push_back({sel_high_bit, sel_low_bit, exp_oe({sel_high_bit, sel_low_bit}, flow_to_alt)});
  end
  always @(negedge sys_clk) if (pend_q[1] && rst_n) begin
    check("function", q.pop_front(), {func_state, c_oe, f_oe, s_oe});
  end
  initial begin
    void'($urandom(18));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    // Flow towards the alternates, then back towards the common port
    for (int p = 0; p < 2; p++) begin
      phase = (p == 0);
      repeat (3) @(negedge sys_clk);
      run = 1'b1;
      repeat (40) @(negedge sys_clk);
      run = 1'b0;
      repeat (4) @(negedge sys_clk);
      $display("test flow %0d done", p);
    end
    // Second reset mid-run must reopen the switch
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("reset state", 5'h0, {func_state, c_oe, f_oe, s_oe});
    $display("test reset done");
    give_verdict();
  end
  // Whole run is near 100 cycles
  initial begin
    #10000;
    error_cnt++;
    give_verdict();
  end
endmodule // sbs_bus_select_tb
